//--- bench/sepi_host.sv
// Host controller model: select, serial clock and data in.
// Assumes no pull on the data line; a released line shows the inverse.
`timescale 1ns/1ps
`default_nettype none
module sepi_host (
   output logic     cs,
   output logic     sclk,
   output logic     di,
   input wire logic dout,
   input wire logic oe
);
   logic last = 1'b0;
   wire  line = oe ? dout : ~last;
   always @(dout or oe) if (oe) last = dout;
   initial begin
      cs = 1'b0;
      sclk = 1'b0;
      di = 1'b0;
   end
   // Select change, then hold past the deselect minimum
   task sel(input logic v);
      cs = v;
      #300;
   endtask
   // One bit, data set in low phase, line sampled before the rise
   task bit_io(input logic b, output logic r);
      di = b;
      #62.5 r = line;
      sclk = 1'b1;
      #62.5 sclk = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- bench/sepi_props.sv
// Timing checker for the serial pin interface.
// Assumes ce goes low only while the link is idle; bound to every sepi_top.
`timescale 1ns/1ps
`default_nettype none
module sepi_props #(
   parameter [1:0] ORG_VARIANT = 2'h0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic chip_select,
   input wire logic serial_clock,
   input wire logic word_width_strap,
   input wire logic serial_data_output,
   input wire logic serial_data_output_oe,
   input wire logic start_seen,
   input wire logic rx_valid,
   input wire logic word_x16,
   input wire logic prog_busy,
   input wire logic read_go
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   rst_quiet_a: assert property (disable iff (1'b0) rst |=> !serial_data_output_oe && !rx_valid)
      else $error("outputs active after reset");
   desel_hiz_a: assert property (!chip_select [*5] |-> !serial_data_output_oe)
      else $error("output driven while deselected");
   oe_needs_sel_a: assert property (serial_data_output_oe |-> $past(chip_select, 3) || $past(chip_select, 4))
      else $error("output driven without select");
   rx_one_a: assert property (rx_valid |=> !rx_valid)
      else $error("bit pulse too long");
   rx_rise_a: assert property (rx_valid |-> $past(serial_clock, 2))
      else $error("bit taken off the rising edge");
   status_busy_a: assert property ($rose(serial_data_output_oe) && $past(chip_select, 3)
      && !$past(chip_select, 4) |-> serial_data_output == !$past(prog_busy))
      else $error("status level wrong");
   status_ready_a: assert property ($fell(prog_busy) && serial_data_output_oe |=> serial_data_output)
      else $error("ready not shown");
   read_start_a: assert property (read_go && chip_select && $past(chip_select, 4) |-> ##2 serial_data_output_oe)
      else $error("read did not drive output");
   strap_width_a: assert property ((ORG_VARIANT == 2'h0) ##0 $stable(word_width_strap) [*4] |-> word_x16 == word_width_strap)
      else $error("word width not from strap");
   read_c: cover property (read_go);
   status_c: cover property ($rose(serial_data_output_oe) && $past(chip_select, 3) && !$past(chip_select, 4));
   start_c: cover property (start_seen);
endmodule
bind sepi_top sepi_props #(.ORG_VARIANT(ORG_VARIANT)) sepi_props_inst (.clk(clk), .rst(rst),
   .chip_select(chip_select), .serial_clock(serial_clock), .word_width_strap(word_width_strap),
   .serial_data_output(serial_data_output), .serial_data_output_oe(serial_data_output_oe),
   .start_seen(start_seen), .rx_valid(rx_valid), .word_x16(word_x16), .prog_busy(prog_busy),
   .read_go(read_go));
`default_nettype wire

//--- bench/sepi_top_tb_top.sv
// Self-checking bench for sepi_top with a host model.
// Assumes ce goes low only while the link is idle; fixed variants watched for width.
`timescale 1ns/1ps
`default_nettype none
module sepi_top_tb_top;
   logic        clk = 0, rst = 1, strap = 0, pst = 0, pbusy = 0, rgo = 0, wv = 0, r, cmd = 0;
   logic        ce = 1;
   logic [15:0] wd = 0;
   wire         cs, sclk, di, sdo, oe, rxv, rxb, x16, wr, ss, fx8, fx16;
   int          errors = 0, checked = 0, fq[$], bq[$], n, i, starts = 0;
   always #5 clk = ~clk;
   sepi_top sepi_top_inst (.clk(clk), .rst(rst), .ce(ce), .chip_select(cs), .serial_clock(sclk),
      .serial_data_input(di), .word_width_strap(strap), .serial_data_output(sdo),
      .serial_data_output_oe(oe), .start_seen(ss), .rx_valid(rxv), .rx_bit(rxb), .word_x16(x16),
      .prog_start(pst), .prog_busy(pbusy), .read_go(rgo), .rd_word_valid(wv), .rd_word_data(wd),
      .rd_word_ready(wr));
   // Fixed-width variants share the stimulus; only their word width is compared
   sepi_top #(.ORG_VARIANT(2'h1)) sepi_top_inst_fx8 (.clk(clk), .rst(rst), .ce(ce),
      .chip_select(cs), .serial_clock(sclk), .serial_data_input(di), .word_width_strap(strap),
      .serial_data_output(), .serial_data_output_oe(), .start_seen(), .rx_valid(), .rx_bit(),
      .word_x16(fx8), .prog_start(pst), .prog_busy(pbusy), .read_go(rgo), .rd_word_valid(wv),
      .rd_word_data(wd), .rd_word_ready());
   sepi_top #(.ORG_VARIANT(2'h2)) sepi_top_inst_fx16 (.clk(clk), .rst(rst), .ce(ce),
      .chip_select(cs), .serial_clock(sclk), .serial_data_input(di), .word_width_strap(strap),
      .serial_data_output(), .serial_data_output_oe(), .start_seen(), .rx_valid(), .rx_bit(),
      .word_x16(fx16), .prog_start(pst), .prog_busy(pbusy), .read_go(rgo), .rd_word_valid(wv),
      .rd_word_data(wd), .rd_word_ready());
   sepi_host sepi_host_inst (.cs(cs), .sclk(sclk), .di(di), .dout(sdo), .oe(oe));
   task chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task stop_test;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) if (rxv && cmd) chk(rxb, bq.pop_front());
   always @(posedge clk) if (ss) starts++;
   task push(input int cnt, input int mask);
      for (i = 0; i < cnt; i++) begin
         @(posedge clk);
         #1 wv = 1;
         wd = $urandom & mask;
         fq.push_back(wd);
      end
      @(posedge clk);
      #1 wv = 0;
   endtask
   task rdf(input int nw, input int w);
      int es[$];
      int j, v;
      es = {0};
      repeat (nw) begin
         v = fq.pop_front();
         for (j = w - 1; j >= 0; j--) es.push_back((v >> j) & 1);
      end
      sepi_host_inst.sel(1);
      bq = {1, 0};
      cmd = 1;
      for (j = 0; j < 3; j++) sepi_host_inst.bit_io(j < 2, r);
      repeat (8) @(posedge clk);
      #1 cmd = 0;
      rgo = 1;
      @(posedge clk);
      #1 rgo = 0;
      sepi_host_inst.bit_io(0, r);
      for (j = 0; j < es.size(); j++) begin
         sepi_host_inst.bit_io(0, r);
         chk(r, es[j]);
      end
      sepi_host_inst.sel(0);
   endtask
   initial begin
      #100000;
      errors++;
      stop_test;
   end
   initial begin
      n = $urandom(77);
      repeat (12) @(posedge clk);
      #1 rst = 0;
      // A programming start while ce is low must leave no status pending
      ce = 0;
      pst = 1;
      repeat (2) @(posedge clk);
      #1 pst = 0;
      ce = 1;
      repeat (30) @(posedge clk);
      #1 sepi_host_inst.sel(1);
      chk(oe, 0);
      sepi_host_inst.sel(0);
      push(16, 'hff);
      chk(wr, 0);
      chk(x16, 0);
      chk({fx8, fx16}, 2'b01);
      rdf(16, 8);
      chk(wr, 1);
      @(posedge clk);
      #1 strap = 1;
      push(2, 'hffff);
      chk(x16, 1);
      chk({fx8, fx16}, 2'b01);
      rdf(2, 16);
      @(posedge clk);
      #1 pst = 1;
      pbusy = 1;
      @(posedge clk);
      #1 pst = 0;
      sepi_host_inst.sel(1);
      chk({oe, sdo}, 2'b10);
      pbusy = 0;
      repeat (3) @(posedge clk);
      #1 chk({oe, sdo}, 2'b11);
      sepi_host_inst.bit_io(1, r);
      sepi_host_inst.sel(0);
      sepi_host_inst.sel(1);
      chk(oe, 0);
      sepi_host_inst.sel(0);
      @(posedge clk);
      #1 pst = 1;
      pbusy = 1;
      @(posedge clk);
      #1 pst = 0;
      repeat (20) @(posedge clk);
      #1 pbusy = 0;
      chk(oe, 0);
      sepi_host_inst.sel(1);
      chk({oe, sdo}, 2'b11);
      sepi_host_inst.sel(0);
      chk(starts, 3);
      stop_test;
   end
endmodule
`default_nettype wire

//--- include/sepi_defs.vh
// Constants for the serial EEPROM pin interface.
// Assumes a 100 MHz system clock that oversamples the serial pins.
`ifndef SEPI_DEFS_VH
`define SEPI_DEFS_VH

`define SEPI_CLK_NS       10
`define SEPI_TCSL_NS      250
`define SEPI_TCSL_CYC     ((`SEPI_TCSL_NS + `SEPI_CLK_NS - 1) / `SEPI_CLK_NS)
`define SEPI_CSL_CNT_W    5
`define SEPI_CSL_CNT_MAX  5'h1f

`define SEPI_WORD_W       16
`define SEPI_BITS_W       5
`define SEPI_X8_LAST      5'h07
`define SEPI_X16_LAST     5'h0f
`define SEPI_FIFO_DEPTH   16
`define SEPI_FIFO_AW      4

`define SEPI_ORG_STRAP    2'h0
`define SEPI_ORG_FIX_X8   2'h1
`define SEPI_ORG_FIX_X16  2'h2

`endif

//--- src/sepi_fifo.v
// Word FIFO in flip-flops with valid/ready on both sides.
// Assumes a single clock; ce low freezes all state.
`timescale 1ns/1ps
`default_nettype none
module sepi_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             ce,
   input  wire             in_valid,
   input  wire [WIDTH-1:0] in_data,
   output reg              in_ready,
   output reg              out_valid,
   output wire [WIDTH-1:0] out_data,
   input  wire             out_ready
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_idx;
   reg  [AW-1:0]    rd_idx;
   reg  [AW:0]      count;
   wire             push = in_valid & in_ready;
   wire             pop  = out_valid & out_ready;
   reg  [AW:0]      next_count;

   assign out_data = mem[rd_idx];

   always @* begin
      next_count = count;
      if (push & ~pop)
         next_count = count + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
         next_count = count - {{AW{1'b0}}, 1'b1};
   end

   always @(posedge clk) begin
      if (rst) begin
         wr_idx    <= {AW{1'b0}};
         rd_idx    <= {AW{1'b0}};
         count     <= {(AW+1){1'b0}};
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else if (ce) begin
         if (push) begin
            mem[wr_idx] <= in_data;
            wr_idx      <= wr_idx + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop)
            rd_idx <= rd_idx + {{(AW-1){1'b0}}, 1'b1};
         count     <= next_count;
         in_ready  <= (next_count != DEPTH[AW:0]);
         out_valid <= (next_count != {(AW+1){1'b0}});
      end
   end
endmodule
`default_nettype wire

//--- src/sepi_top.v
// Pin-side logic of a three-wire serial EEPROM: input capture, read shifter,
// ready/busy status on the data output and word-width selection.
// Assumes the array core gives prog_start/prog_busy/read_go on clk and
// fills read words through the FIFO; serial pins are asynchronous.
//
// Functional notes
// RULE1 - Bits on data input sampled per serial clock
// RULE2 - Read data shifted out after rising edges
// RULE3 - Status shown when select rises after deselect
// RULE4 - Select low throughout programming: output high-Z
// RULE5 - Finished programming reads as output high
// RULE6 - Start bit then select low clears status
// RULE7 - Strap high 16-bit words, low 8-bit
// RULE8 - Fixed variants use permanent word width
// RULE9 - Status low while busy, high when ready
// RULE10 - Select low holds control logic in reset
// RULE11 - Capture and launch on rising serial edge
// RULE12 - Dummy zero bit precedes read word
// RULE13 - Idle and deselected output stays high-Z
`timescale 1ns/1ps
`default_nettype none
`include "sepi_defs.vh"
module sepi_top #(
   parameter [1:0] ORG_VARIANT = `SEPI_ORG_STRAP
) (
   input  wire                    clk,
   input  wire                    rst,
   input  wire                    ce,
   input  wire                    chip_select,
   input  wire                    serial_clock,
   input  wire                    serial_data_input,
   input  wire                    word_width_strap,
   output reg                     serial_data_output,
   output reg                     serial_data_output_oe,
   output reg                     start_seen,
   output reg                     rx_valid,
   output reg                     rx_bit,
   output reg                     word_x16,
   input  wire                    prog_start,
   input  wire                    prog_busy,
   input  wire                    read_go,
   input  wire                    rd_word_valid,
   input  wire [`SEPI_WORD_W-1:0] rd_word_data,
   output wire                    rd_word_ready
);
   localparam [2:0] ST_WAIT = 3'h1;
   localparam [2:0] ST_RECV = 3'h2;
   localparam [2:0] ST_READ = 3'h4;

   reg                       cs_m, cs_s, cs_d;
   reg                       sck_m, sck_s, sck_d;
   reg                       di_m, di_s;
   reg                       org_m, org_s;
   reg [`SEPI_CSL_CNT_W-1:0] csl_cnt;
   reg                       prog_pending;
   reg                       status_on;
   reg                       clear_arm;
   reg [2:0]                 state;
   reg                       need_dummy;
   reg [`SEPI_BITS_W-1:0]    bits_left;
   reg [`SEPI_WORD_W-1:0]    shreg;
   wire                      f_valid;
   wire [`SEPI_WORD_W-1:0]   f_data;
   wire                      sck_rise = sck_s & ~sck_d;
   wire                      cs_rise  = cs_s & ~cs_d;
   wire                      cs_fall  = ~cs_s & cs_d;
   wire [31:0]               csl_ext  = {27'h0, csl_cnt};
   wire                      csl_ok   = (csl_ext >= `SEPI_TCSL_CYC);
   wire                      load     = (state == ST_READ) & sck_rise & ~need_dummy
                                        & (bits_left == {`SEPI_BITS_W{1'b0}}) & f_valid;
   wire                      org_x16;
   wire [`SEPI_WORD_W-1:0]   word_al;

   assign org_x16 = (ORG_VARIANT == `SEPI_ORG_FIX_X16) ? 1'b1 :
                    (ORG_VARIANT == `SEPI_ORG_FIX_X8)  ? 1'b0 : org_s;  // [RULE7] [RULE8]
   // An 8-bit word is moved to the top so the shifter always sends bit 15 first
   assign word_al = word_x16 ? f_data : {f_data[7:0], 8'h00};

   sepi_fifo #(
      .WIDTH (`SEPI_WORD_W),
      .DEPTH (`SEPI_FIFO_DEPTH),
      .AW    (`SEPI_FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .in_valid  (rd_word_valid),
      .in_data   (rd_word_data),
      .in_ready  (rd_word_ready),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (load)
   );

   always @(posedge clk) begin
      if (rst) begin
         cs_m  <= 1'b0;
         cs_s  <= 1'b0;
         cs_d  <= 1'b0;
         sck_m <= 1'b0;
         sck_s <= 1'b0;
         sck_d <= 1'b0;
         di_m  <= 1'b0;
         di_s  <= 1'b0;
         org_m <= 1'b0;
         org_s <= 1'b0;
      end else if (ce) begin
         cs_m  <= chip_select;
         cs_s  <= cs_m;
         cs_d  <= cs_s;
         sck_m <= serial_clock;
         sck_s <= sck_m;
         sck_d <= sck_s;
         di_m  <= serial_data_input;
         di_s  <= di_m;
         org_m <= word_width_strap;
         org_s <= org_m;
      end
   end

   // Deselect time and ready/busy bookkeeping
   always @(posedge clk) begin
      if (rst) begin
         csl_cnt      <= {`SEPI_CSL_CNT_W{1'b0}};
         prog_pending <= 1'b0;
         status_on    <= 1'b0;
         clear_arm    <= 1'b0;
      end else if (ce) begin
         if (~cs_s) begin
            if (csl_cnt != `SEPI_CSL_CNT_MAX)
               csl_cnt <= csl_cnt + {{(`SEPI_CSL_CNT_W-1){1'b0}}, 1'b1};
         end else begin
            csl_cnt <= {`SEPI_CSL_CNT_W{1'b0}};
         end
         if (prog_start)
            prog_pending <= 1'b1;                                       // [RULE3]
         else if (cs_fall & clear_arm)
            prog_pending <= 1'b0;                                       // [RULE6]
         if (~cs_s)
            status_on <= 1'b0;                                          // [RULE4]
         else if (cs_rise & csl_ok & prog_pending)
            status_on <= 1'b1;                                          // [RULE3]
         if (~cs_s & ~cs_fall)
            clear_arm <= 1'b0;
         else if (cs_s & prog_pending & ~prog_busy & (state == ST_WAIT) & sck_rise & di_s)
            clear_arm <= 1'b1;                                          // [RULE6]
      end
   end

   // Serial sequencing; select low is the reset of this logic
   always @(posedge clk) begin
      if (rst) begin
         state                 <= ST_WAIT;
         need_dummy            <= 1'b0;
         bits_left             <= {`SEPI_BITS_W{1'b0}};
         shreg                 <= {`SEPI_WORD_W{1'b0}};
         word_x16              <= 1'b0;
         start_seen            <= 1'b0;
         rx_valid              <= 1'b0;
         rx_bit                <= 1'b0;
         serial_data_output    <= 1'b0;
         serial_data_output_oe <= 1'b0;
      end else if (ce) begin
         start_seen <= 1'b0;
         rx_valid   <= 1'b0;
         word_x16   <= org_x16;                                         // [RULE7]
         if (~cs_s) begin
            state                 <= ST_WAIT;                           // [RULE10]
            need_dummy            <= 1'b0;
            bits_left             <= {`SEPI_BITS_W{1'b0}};
            serial_data_output_oe <= 1'b0;                              // [RULE13]
         end else begin
            case (state)
               ST_WAIT: begin
                  if (sck_rise & di_s) begin
                     state      <= ST_RECV;
                     start_seen <= 1'b1;                                // [RULE1]
                  end
               end
               ST_RECV: begin
                  if (read_go) begin
                     state      <= ST_READ;
                     need_dummy <= 1'b1;
                  end else if (sck_rise) begin
                     rx_valid <= 1'b1;                                  // [RULE11]
                     rx_bit   <= di_s;                                  // [RULE1]
                  end
               end
               ST_READ: begin
                  if (sck_rise) begin
                     if (need_dummy) begin
                        serial_data_output <= 1'b0;                     // [RULE12]
                        need_dummy         <= 1'b0;
                     end else if (bits_left == {`SEPI_BITS_W{1'b0}}) begin
                        if (f_valid) begin
                           serial_data_output <= word_al[`SEPI_WORD_W-1]; // [RULE2]
                           shreg     <= {word_al[`SEPI_WORD_W-2:0], 1'b0};
                           bits_left <= word_x16 ? `SEPI_X16_LAST : `SEPI_X8_LAST; // [RULE12]
                        end
                     end else begin
                        serial_data_output <= shreg[`SEPI_WORD_W-1];    // [RULE11]
                        shreg     <= {shreg[`SEPI_WORD_W-2:0], 1'b0};
                        bits_left <= bits_left - {{(`SEPI_BITS_W-1){1'b0}}, 1'b1};
                     end
                  end
               end
               default: state <= ST_WAIT;
            endcase
            if (state == ST_READ) begin
               serial_data_output_oe <= 1'b1;                           // [RULE2]
            end else if (status_on | (cs_rise & csl_ok & prog_pending)) begin
               serial_data_output_oe <= 1'b1;                           // [RULE3]
               serial_data_output    <= ~prog_busy;                     // [RULE5] [RULE9]
            end else begin
               serial_data_output_oe <= 1'b0;                           // [RULE13]
            end
         end
      end
   end
endmodule
`default_nettype wire
